// ===== core/rtcc_pkg.sv
`default_nettype none

package rtcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration access
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam logic [7:0]  RETRY_REG_OFS  = 8'h90;
  localparam logic [7:0]  CARD_REG_OFS   = 8'h91;

  ////////////////////////////////////////////////////////////////////////////
  // Retry time-out control and flags
  localparam logic [7:0]  RETRY_RST      = 8'hC0;
  localparam int          HOST_EN_BIT    = 7;
  localparam int          CARD_EN_BIT    = 6;
  localparam int          TGT_B_BIT      = 5;
  localparam int          TGT_A_BIT      = 3;
  localparam int          HOST_EXP_BIT   = 1;
  localparam logic        HOST_EN_RST    = 1'b1;
  localparam logic        CARD_EN_RST    = 1'b1;
  localparam logic        FLAG_RST       = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Card feature control
  localparam logic [7:0]  CARD_RST       = 8'h00;
  localparam int          RING_EN_BIT    = 7;
  localparam int          VIDEO_EN_BIT   = 6;
  localparam int          VIDEO_PRI_BIT  = 5;
  localparam int          AUDIO_BIT      = 2;
  localparam int          SPK_BIT        = 1;
  localparam int          IRQ_BIT        = 0;
  localparam logic        CTL_BIT_RST    = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Retry time-out: 2^15 bus clocks
  localparam int          RETRY_LIMIT_LOG2    = 15;
  localparam int          RETRY_LIMIT_DEFAULT = 2 ** RETRY_LIMIT_LOG2;
  localparam int          TMR_W               = RETRY_LIMIT_LOG2 + 1;

  typedef enum logic {
    TMR_IDLE = 1'b0,
    TMR_RUN  = 1'b1
  } rtcc_tmr_state_e;

endpackage : rtcc_pkg

`default_nettype wire

// ===== core/rtcc_retry_card_ctl.sv
`default_nettype none

// Summary of operation
// RQ1 - Unreturned retry after 2^15 clocks sets flag
// RQ2 - Expiry flags stay until one written
// RQ3 - Bit 7 enables host retry counter
// RQ4 - Bit 6 enables card retry counter
// RQ5 - Bit 5 shows card target B expiry
// RQ6 - Bit 3 shows card target A expiry
// RQ7 - Bit 1 shows host target expiry
// RQ8 - Retry bits 4, 2, 0 read zero
// RQ9 - Only global reset restores register defaults
// RQ10 - Software reaches retry register at 90h
// RQ11 - Bit 7 enables ring indicate output
// RQ12 - Bit 6 floats socket video port
// RQ13 - Bit 5 picks video priority socket
// RQ14 - Bit 2 zero routes audio PWM
// RQ15 - Bit 1 forwards card speaker out
// RQ16 - Card functional interrupt sets bit 0
// RQ17 - Writing one clears interrupt flag
// RQ18 - Card control bits 4, 3 read zero
// RQ19 - Retry timer restarts, stops on return/disable
module rtcc_retry_card_ctl #(
  parameter int RETRY_LIMIT = rtcc_pkg::RETRY_LIMIT_DEFAULT
)
(
  // Clock and resets
  input  wire logic                       mclk,
  input  wire logic                       sys_rst,
  input  wire logic                       func_rst,
  // Configuration access
  input  wire logic                       cfg_wr_en,
  input  wire logic                       cfg_rd_en,
  input  wire logic [rtcc_pkg::ADDR_W-1:0] cfg_addr,
  input  wire logic [rtcc_pkg::DATA_W-1:0] cfg_wdata,
  output logic      [rtcc_pkg::DATA_W-1:0] cfg_rdata,
  output logic                            cfg_rd_valid,
  // Host-side target retries
  input  wire logic                       host_retry_issue,
  input  wire logic                       host_retry_return,
  // Card-side target retries
  input  wire logic                       card_a_retry_issue,
  input  wire logic                       card_a_retry_return,
  input  wire logic                       card_b_retry_issue,
  input  wire logic                       card_b_retry_return,
  // Card events
  input  wire logic                       card_ring_in,
  input  wire logic                       card_func_irq_in,
  input  wire logic                       card_audio_in,
  input  wire logic                       card_speaker_in,
  // Video port arbitration
  input  wire logic                       this_socket_is_1,
  input  wire logic                       video_peer_mode_en,
  // Terminal controls
  output logic                            ring_indicate_out_n,
  output logic                            video_port_oe,
  output logic                            video_port_mode_en,
  output logic                            video_select_sock0_n,
  output logic                            video_select_sock1_n,
  output logic                            card_audio_pwm_out,
  output logic                            card_audio_pwm_oe,
  output logic                            speaker_out,
  output logic                            card_func_irq_flag
);
  import rtcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic wr_retry;
  logic wr_card;
  logic tmr_rst;

  // Function reset only stops timers; register bits ride through it
  assign tmr_rst  = sys_rst || func_rst; // see RQ9
  assign wr_retry = cfg_wr_en && (cfg_addr == RETRY_REG_OFS); // see RQ10
  assign wr_card  = cfg_wr_en && (cfg_addr == CARD_REG_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Retry control bits

  logic host_retry_count_en_reg;
  logic card_retry_count_en_reg;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      host_retry_count_en_reg <= HOST_EN_RST; // see RQ9
    else if (wr_retry)
      host_retry_count_en_reg <= cfg_wdata[HOST_EN_BIT]; // see RQ3
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      card_retry_count_en_reg <= CARD_EN_RST; // see RQ9
    else if (wr_retry)
      card_retry_count_en_reg <= cfg_wdata[CARD_EN_BIT]; // see RQ4
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retry timers and expiry flags

  logic host_expire;
  logic card_a_expire;
  logic card_b_expire;
  logic host_tgt_retry_expired;
  logic card_tgt_a_retry_expired;
  logic card_tgt_b_retry_expired;

  rtcc_retry_timer #(.LIMIT(RETRY_LIMIT)) u_host_tmr (
    .mclk          (mclk),
    .tmr_rst       (tmr_rst),
    .count_en      (host_retry_count_en_reg), // see RQ3
    .retry_issue   (host_retry_issue),
    .master_return (host_retry_return),
    .expire        (host_expire)
  );

  rtcc_retry_timer #(.LIMIT(RETRY_LIMIT)) u_card_a_tmr (
    .mclk          (mclk),
    .tmr_rst       (tmr_rst),
    .count_en      (card_retry_count_en_reg), // see RQ4
    .retry_issue   (card_a_retry_issue),
    .master_return (card_a_retry_return),
    .expire        (card_a_expire)
  );

  rtcc_retry_timer #(.LIMIT(RETRY_LIMIT)) u_card_b_tmr (
    .mclk          (mclk),
    .tmr_rst       (tmr_rst),
    .count_en      (card_retry_count_en_reg), // see RQ4
    .retry_issue   (card_b_retry_issue),
    .master_return (card_b_retry_return),
    .expire        (card_b_expire)
  );

  rtcc_sticky_flag u_host_flag (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .set_evt (host_expire),
    .clr_req (wr_retry && cfg_wdata[HOST_EXP_BIT]), // see RQ2
    .flag    (host_tgt_retry_expired)
  );

  rtcc_sticky_flag u_card_a_flag (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .set_evt (card_a_expire),
    .clr_req (wr_retry && cfg_wdata[TGT_A_BIT]), // see RQ2
    .flag    (card_tgt_a_retry_expired)
  );

  rtcc_sticky_flag u_card_b_flag (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .set_evt (card_b_expire),
    .clr_req (wr_retry && cfg_wdata[TGT_B_BIT]), // see RQ2
    .flag    (card_tgt_b_retry_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Card feature control bits

  logic ring_out_en_reg;
  logic video_en_reg;
  logic video_pri_reg;
  logic card_audio_route_ctl_reg;
  logic speaker_forward_en_reg;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ring_out_en_reg          <= CTL_BIT_RST; // see RQ9
      video_en_reg             <= CTL_BIT_RST;
      video_pri_reg            <= CTL_BIT_RST;
      card_audio_route_ctl_reg <= CTL_BIT_RST;
      speaker_forward_en_reg   <= CTL_BIT_RST;
    end
    else if (wr_card)
    begin
      ring_out_en_reg          <= cfg_wdata[RING_EN_BIT];
      video_en_reg             <= cfg_wdata[VIDEO_EN_BIT];
      video_pri_reg            <= cfg_wdata[VIDEO_PRI_BIT];
      card_audio_route_ctl_reg <= cfg_wdata[AUDIO_BIT];
      speaker_forward_en_reg   <= cfg_wdata[SPK_BIT];
    end
  end

  rtcc_sticky_flag u_irq_flag (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .set_evt (card_func_irq_in), // see RQ16
    .clr_req (wr_card && cfg_wdata[IRQ_BIT]), // see RQ17
    .flag    (card_func_irq_flag)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read-back

  logic [DATA_W-1:0] retry_view;
  logic [DATA_W-1:0] card_view;
  logic [DATA_W-1:0] rdata_reg;
  logic              rd_valid_reg;

  always_comb
  begin
    retry_view               = '0; // see RQ8
    retry_view[HOST_EN_BIT]  = host_retry_count_en_reg;
    retry_view[CARD_EN_BIT]  = card_retry_count_en_reg;
    retry_view[TGT_B_BIT]    = card_tgt_b_retry_expired; // see RQ5
    retry_view[TGT_A_BIT]    = card_tgt_a_retry_expired; // see RQ6
    retry_view[HOST_EXP_BIT] = host_tgt_retry_expired; // see RQ7
  end

  always_comb
  begin
    card_view                = '0; // see RQ18
    card_view[RING_EN_BIT]   = ring_out_en_reg;
    card_view[VIDEO_EN_BIT]  = video_en_reg;
    card_view[VIDEO_PRI_BIT] = video_pri_reg;
    card_view[AUDIO_BIT]     = card_audio_route_ctl_reg;
    card_view[SPK_BIT]       = speaker_forward_en_reg;
    card_view[IRQ_BIT]       = card_func_irq_flag;
  end

  // Unmapped offsets read zero; data holds until the next read
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdata_reg <= '0;
    else if (cfg_rd_en)
    begin
      case (cfg_addr)
        RETRY_REG_OFS: rdata_reg <= retry_view;
        CARD_REG_OFS:  rdata_reg <= card_view;
        default:       rdata_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rd_valid_reg <= 1'b0;
    else
      rd_valid_reg <= cfg_rd_en;
  end

  assign cfg_rdata    = rdata_reg;
  assign cfg_rd_valid = rd_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Terminal controls

  logic ring_n_reg;
  logic video_oe_reg;
  logic sel0_n_reg;
  logic sel1_n_reg;
  logic audio_reg;
  logic audio_oe_reg;
  logic speaker_reg;
  logic video_mine;

  // Without a peer in video mode this socket owns the port
  assign video_mine = video_en_reg &&
                      (!video_peer_mode_en || (video_pri_reg == this_socket_is_1));

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ring_n_reg   <= 1'b1;
      video_oe_reg <= 1'b1;
      sel0_n_reg   <= 1'b1;
      sel1_n_reg   <= 1'b1;
      audio_reg    <= 1'b0;
      audio_oe_reg <= 1'b0;
      speaker_reg  <= 1'b0;
    end
    else
    begin
      ring_n_reg   <= !(ring_out_en_reg && card_ring_in); // see RQ11
      video_oe_reg <= !video_en_reg; // see RQ12
      sel0_n_reg   <= !(video_mine && !this_socket_is_1); // see RQ13
      sel1_n_reg   <= !(video_mine && this_socket_is_1); // see RQ13
      audio_reg    <= !card_audio_route_ctl_reg && card_audio_in; // see RQ14
      audio_oe_reg <= !card_audio_route_ctl_reg; // see RQ14
      speaker_reg  <= speaker_forward_en_reg && card_speaker_in; // see RQ15
    end
  end

  assign ring_indicate_out_n  = ring_n_reg;
  assign video_port_oe        = video_oe_reg;
  assign video_port_mode_en   = video_en_reg;
  assign video_select_sock0_n = sel0_n_reg;
  assign video_select_sock1_n = sel1_n_reg;
  assign card_audio_pwm_out   = audio_reg;
  assign card_audio_pwm_oe    = audio_oe_reg;
  assign speaker_out          = speaker_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence retry_rd_s;
    cfg_rd_en && cfg_addr == RETRY_REG_OFS;
  endsequence

  sequence card_rd_s;
    cfg_rd_en && cfg_addr == CARD_REG_OFS;
  endsequence

  reset_value_a: assert property (@(posedge mclk) sys_rst |=>
      retry_view == RETRY_RST && card_view == CARD_RST) // see RQ9
    else $error("register defaults wrong after reset");
  func_rst_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
      func_rst && !cfg_wr_en |=> $stable(card_view[DATA_W-1:1])) // see RQ9
    else $error("function reset disturbed control bits");
  retry_rsvd_a: assert property (@(posedge mclk) disable iff (sys_rst)
      retry_rd_s |=> cfg_rd_valid && cfg_rdata[4] == 1'b0 && cfg_rdata[2] == 1'b0
      && cfg_rdata[0] == 1'b0) // see RQ8
    else $error("retry reserved bits not zero");
  card_rsvd_a: assert property (@(posedge mclk) disable iff (sys_rst)
      card_rd_s |=> cfg_rdata[4:3] == 2'b00) // see RQ18
    else $error("card reserved bits not zero");
  host_flag_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
      retry_rd_s ##0 host_tgt_retry_expired |=> cfg_rdata[HOST_EXP_BIT]) // see RQ7
    else $error("host expiry not visible");
  zero_write_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_retry && cfg_wdata[TGT_A_BIT] == 1'b0 && card_tgt_a_retry_expired
      |=> card_tgt_a_retry_expired) // see RQ2
    else $error("zero write cleared expiry");
  count_en_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      wr_retry |=> host_retry_count_en_reg == $past(cfg_wdata[HOST_EN_BIT])
      && card_retry_count_en_reg == $past(cfg_wdata[CARD_EN_BIT])) // see RQ3
    else $error("counter enables not written");
  ring_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !ring_out_en_reg |=> ring_indicate_out_n) // see RQ11
    else $error("ring output active while disabled");
  video_float_a: assert property (@(posedge mclk) disable iff (sys_rst)
      video_en_reg |=> !video_port_oe) // see RQ12
    else $error("video port driven in video mode");
  video_pri_a: assert property (@(posedge mclk) disable iff (sys_rst)
      video_en_reg && video_peer_mode_en && !video_pri_reg && !this_socket_is_1
      |=> !video_select_sock0_n && video_select_sock1_n) // see RQ13
    else $error("socket 0 priority not signalled");
  speaker_fwd_a: assert property (@(posedge mclk) disable iff (sys_rst)
      speaker_forward_en_reg && card_speaker_in |=> speaker_out ##0
      !(speaker_forward_en_reg == 1'b0 && $past(speaker_forward_en_reg) == 1'b0
      && speaker_out)) // see RQ15
    else $error("speaker not forwarded");
  audio_route_a: assert property (@(posedge mclk) disable iff (sys_rst)
      card_audio_route_ctl_reg |=> !card_audio_pwm_oe && !card_audio_pwm_out) // see RQ14
    else $error("audio routed while disabled");

endmodule // rtcc_retry_card_ctl

`default_nettype wire

// ===== core/rtcc_retry_timer.sv
`default_nettype none

module rtcc_retry_timer #(
  parameter int LIMIT = rtcc_pkg::RETRY_LIMIT_DEFAULT
)
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic tmr_rst,
  // Control
  input  wire logic count_en,
  input  wire logic retry_issue,
  input  wire logic master_return,
  // Expiry pulse
  output logic      expire
);
  import rtcc_pkg::*;

  localparam logic [TMR_W-1:0] LIMIT_M1 = TMR_W'(LIMIT - 1);

  rtcc_tmr_state_e  state_reg;
  logic [TMR_W-1:0] cnt_reg;
  logic             expire_reg;
  logic             at_limit;

  assign at_limit = (state_reg == TMR_RUN) && (cnt_reg == LIMIT_M1) && count_en
                    && !retry_issue && !master_return;

  // A new retry restarts; return or disable stops without expiry
  always_ff @(posedge mclk)
  begin
    if (tmr_rst)
      state_reg <= TMR_IDLE;
    else
    begin
      case (state_reg)
        TMR_IDLE:
          if (retry_issue && count_en)
            state_reg <= TMR_RUN;
        TMR_RUN:
          if (retry_issue && count_en)
            state_reg <= TMR_RUN; // see RQ19
          else if (master_return || !count_en || at_limit)
            state_reg <= TMR_IDLE; // see RQ19
        default:
          state_reg <= TMR_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (tmr_rst)
      cnt_reg <= '0;
    else if (retry_issue)
      cnt_reg <= '0;
    else if (state_reg == TMR_RUN)
      cnt_reg <= cnt_reg + TMR_W'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (tmr_rst)
      expire_reg <= 1'b0;
    else
      expire_reg <= at_limit; // see RQ1
  end

  assign expire = expire_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (tmr_rst);

  expiry_exact_a: assert property (at_limit |=> expire) // see RQ1
    else $error("timer did not expire at limit");
  expiry_cause_a: assert property (expire |-> $past(cnt_reg) == LIMIT_M1) // see RQ1
    else $error("expiry at wrong count");
  disabled_quiet_a: assert property (!count_en |=> !expire) // see RQ19
    else $error("expiry while counter disabled");
  restart_a: assert property (retry_issue && count_en
                              |=> state_reg == TMR_RUN && cnt_reg == '0) // see RQ19
    else $error("retry did not restart timer");
  return_stop_a: assert property (master_return && !retry_issue
                                  |=> state_reg == TMR_IDLE ##1 !expire) // see RQ19
    else $error("timer kept running after return");

endmodule // rtcc_retry_timer

`default_nettype wire

// ===== core/rtcc_sticky_flag.sv
`default_nettype none

module rtcc_sticky_flag
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // Event and clear
  input  wire logic set_evt,
  input  wire logic clr_req,
  // Flag
  output logic      flag
);
  import rtcc_pkg::*;

  logic flag_reg;

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      flag_reg <= FLAG_RST;
    else if (set_evt)
      flag_reg <= 1'b1;
    else if (clr_req)
      flag_reg <= 1'b0;
  end

  assign flag = flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  flag_set_a: assert property (set_evt |=> flag) // see RQ1
    else $error("flag not set after event");
  flag_hold_a: assert property (flag && !clr_req |=> flag [*1]) // see RQ2
    else $error("flag dropped without clear");
  flag_clear_a: assert property (flag && clr_req && !set_evt |=> !flag) // see RQ17
    else $error("flag not cleared by write of one");
  flag_cause_a: assert property ($rose(flag) |-> $past(set_evt)) // see RQ16
    else $error("flag rose without event");

endmodule // rtcc_sticky_flag

`default_nettype wire

// ===== verification/rtcc_far_side.sv
`default_nettype none

// Retried masters on both buses: bit 0 host side, bit 1 card target A, bit 2 card target B
module rtcc_far_side
(
  // Clock
  input  wire logic       mclk,
  // Requests from the bench
  input  wire logic [2:0] go,
  input  wire logic [7:0] ret_dly,
  // Retry lines toward the block
  output logic      [2:0] issue,
  output logic      [2:0] ret
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] cnt [3] = '{default: 8'h00};

  initial
  begin
    issue = 3'h0;
    ret   = 3'h0;
  end

  // Zero delay means the master never comes back
  always @(negedge mclk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      issue[i] <= go[i];
      ret[i]   <= (cnt[i] == 8'h01);
      if (go[i])
        cnt[i] <= ret_dly;
      else if (cnt[i] != 8'h00)
        cnt[i] <= cnt[i] - 8'h01;
    end
  end
endmodule // rtcc_far_side

`default_nettype wire

// ===== verification/tb.sv
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int LIM = 16;

  logic       mclk = 1'b0, sys_rst = 1'b1, func_rst = 1'b0;
  logic       cfg_wr_en = 1'b0, cfg_rd_en = 1'b0, cfg_rd_valid;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
  logic       card_ring_in = 1'b0, card_func_irq_in = 1'b0;
  logic       card_audio_in = 1'b0, card_speaker_in = 1'b0;
  logic       this_socket_is_1 = 1'b0, video_peer_mode_en = 1'b0;
  logic       ring_n, vid_oe, vid_mode, sel0_n, sel1_n, pwm, pwm_oe, spk, irq;
  logic [2:0] go = 3'h0, issue, ret;
  logic [7:0] ret_dly = 8'h00;
  logic [5:0] outs;
  int         miscompares = 0, num_checks = 0;

  initial forever #2.5 mclk = ~mclk;

  rtcc_far_side rtcc_far_side_i (.mclk(mclk), .go(go), .ret_dly(ret_dly), .issue(issue),
    .ret(ret));

  rtcc_retry_card_ctl #(.RETRY_LIMIT(LIM)) rtcc_retry_card_ctl_i (
    .mclk(mclk), .sys_rst(sys_rst), .func_rst(func_rst),
    .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
    .host_retry_issue(issue[0]), .host_retry_return(ret[0]),
    .card_a_retry_issue(issue[1]), .card_a_retry_return(ret[1]),
    .card_b_retry_issue(issue[2]), .card_b_retry_return(ret[2]),
    .card_ring_in(card_ring_in), .card_func_irq_in(card_func_irq_in),
    .card_audio_in(card_audio_in), .card_speaker_in(card_speaker_in),
    .this_socket_is_1(this_socket_is_1), .video_peer_mode_en(video_peer_mode_en),
    .ring_indicate_out_n(ring_n), .video_port_oe(vid_oe), .video_port_mode_en(vid_mode),
    .video_select_sock0_n(sel0_n), .video_select_sock1_n(sel1_n),
    .card_audio_pwm_out(pwm), .card_audio_pwm_oe(pwm_oe), .speaker_out(spk),
    .card_func_irq_flag(irq));

  // Only this socket's select goes into outs; the peer's select belongs to the other function
  assign outs = {ring_n, vid_oe, this_socket_is_1 ? sel1_n : sel0_n, pwm, pwm_oe, spk};

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Software only touches the two mapped offsets, plus deliberate unmapped probes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr_en = 1'b1;
    @(negedge mclk);
    cfg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int n;
    n = 0;
    cfg_addr = a;
    cfg_rd_en = 1'b1;
    @(negedge mclk);
    cfg_rd_en = 1'b0;
    while (cfg_rd_valid !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    if (cfg_rd_valid !== 1'b1)
    begin
      miscompares++;
      close_out();
    end
    else
    begin
      chk(cfg_rdata, e);
      // Free edge so a following read never re-raises the strobe in this step
      @(negedge mclk);
    end
  endtask

  // Clear flags, set enables, launch retries, look just before and after the limit
  task automatic retry(input logic [2:0] ch, input logic [7:0] dly, input logic [7:0] en,
                       input logic [7:0] e);
    wr(8'h90, en | 8'h2A);
    ret_dly <= dly;
    go <= ch;
    @(negedge mclk);
    go <= 3'h0;
    repeat (LIM - 2) @(negedge mclk);
    rd(8'h90, en);
    repeat (4) @(negedge mclk);
    rd(8'h90, e);
    $display("retry case %h done", ch);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Row: offset, write data, read back, {ring, audio, speaker, socket1, peer}, outputs
  logic [34:0] rows [12] = '{
    {8'h90, 8'h00, 8'h00, 5'h00, 6'h3A}, {8'h90, 8'hFF, 8'hC0, 5'h00, 6'h3A},
    {8'h92, 8'hFF, 8'h00, 5'h00, 6'h3A}, {8'h91, 8'hFF, 8'hE6, 5'h00, 6'h20},
    {8'h91, 8'h00, 8'h00, 5'h1C, 6'h3E}, {8'h91, 8'h80, 8'h80, 5'h14, 6'h1A},
    {8'h91, 8'h06, 8'h06, 5'h0C, 6'h39}, {8'h91, 8'h40, 8'h40, 5'h01, 6'h22},
    {8'h91, 8'h40, 8'h40, 5'h03, 6'h2A}, {8'h91, 8'h60, 8'h60, 5'h03, 6'h22},
    {8'h91, 8'h60, 8'h60, 5'h02, 6'h22}, {8'h91, 8'h60, 8'h60, 5'h01, 6'h2A}};

  initial
  begin
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    rd(8'h90, 8'hC0);
    rd(8'h91, 8'h00);
    chk({sel1_n, vid_mode, outs}, 8'hBA);
    $display("reset test done");
    foreach (rows[i])
    begin
      {card_ring_in, card_audio_in, card_speaker_in, this_socket_is_1,
        video_peer_mode_en} = rows[i][10:6];
      wr(rows[i][34:27], rows[i][26:19]);
      rd(rows[i][34:27], rows[i][18:11]);
      chk({2'b00, outs}, {2'b00, rows[i][5:0]});
      $display("row %0d done", i);
    end
    retry(3'h1, 8'h00, 8'hC0, 8'hC2);
    retry(3'h6, 8'h00, 8'hC0, 8'hE8);
    retry(3'h7, 8'h05, 8'hC0, 8'hC0);
    retry(3'h1, 8'h00, 8'h40, 8'h40);
    retry(3'h6, 8'h00, 8'h80, 8'h80);
    retry(3'h1, 8'h00, 8'hC0, 8'hC2);
    wr(8'h90, 8'hC0);
    rd(8'h90, 8'hC2);
    wr(8'h90, 8'hC2);
    rd(8'h90, 8'hC0);
    card_func_irq_in = 1'b1;
    @(negedge mclk);
    card_func_irq_in = 1'b0;
    rd(8'h91, 8'h61);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, vid_mode}, 8'h01);
    wr(8'h91, 8'h60);
    rd(8'h91, 8'h61);
    wr(8'h91, 8'h61);
    rd(8'h91, 8'h60);
    $display("flag test done");
    func_rst = 1'b1;
    @(negedge mclk);
    func_rst = 1'b0;
    rd(8'h91, 8'h60);
    sys_rst = 1'b1;
    @(negedge mclk);
    sys_rst = 1'b0;
    rd(8'h90, 8'hC0);
    rd(8'h91, 8'h00);
    chk({sel1_n, vid_mode, outs}, 8'hBA);
    $display("reset repeat done");
    close_out();
  end
endmodule // tb

`default_nettype wire
